//--- hdl/bao_pkg.sv
// Notes on behaviour
// RULE1 - four id words at 2000h..2003h
// RULE2 - id words reachable only in program mode
// RULE3 - only low seven id bits stored
// RULE4 - add literal to accumulator, update flags
// RULE5 - add accumulator and file register, flags
// RULE6 - destination bit picks accumulator or file
// RULE7 - and literal into accumulator, zero only
// RULE8 - and file register, zero flag only
// RULE9 - bit clear leaves other bits, flags
// RULE10 - bit set leaves other bits, flags
// RULE11 - test clear skips next, nop cycle
// RULE12 - carry bit7, nibble carry bit3, zero
// RULE13 - bit ops are whole-byte read-modify-write
package bao_pkg;
  // ****************************************
  // operation codes from the decoder
  // ****************************************
  typedef enum logic [2:0] {
    BAO_OP_NONE = 3'h0, // idle or other instruction
    BAO_OP_ADD_LIT = 3'h1, // add_literal_op
    BAO_OP_ADD_FILE = 3'h2, // add_file_op
    BAO_OP_AND_LIT = 3'h3, // and_literal_op
    BAO_OP_AND_FILE = 3'h4, // and_file_op
    BAO_OP_BIT_CLR = 3'h5, // bit_clear_op
    BAO_OP_BIT_SET = 3'h6, // bit_set_op
    BAO_OP_BIT_TST = 3'h7 // bit_test_skip_if_low
  } bao_op_t;

  // ****************************************
  // widths, addresses and reset values
  // ****************************************
  localparam int BAO_DATA_W = 8; // byte datapath
  localparam int BAO_FADDR_W = 7; // file address 0..127
  localparam int BAO_ID_W = 7; // stored id bits
  localparam int BAO_ID_NUM = 4; // id words
  localparam logic [13:0] BAO_ID_BASE = 14'h2000; // first id address
  localparam logic [13:0] BAO_ID_LAST = 14'h2003; // last id address
  localparam logic [7:0] BAO_ACC_RST = 8'h00; // accumulator after reset
  localparam logic [6:0] BAO_ID_RST = 7'h00; // id words after reset
  localparam int BAO_NIB_BIT = 4; // carry out of bit 3 lands here
endpackage

//--- hdl/bao_flag_calc.sv
`timescale 1ns/1ps
// ****************************************
// adder / and unit with status flags
// ****************************************
module bao_flag_calc
  import bao_pkg::*;
(
  input wire logic [7:0] acc_i,
  input wire logic [7:0] opnd_i,
  input wire logic add_i, // high adds, low ands
  output logic [7:0] res_o,
  output logic carry_o,
  output logic nib_o,
  output logic zero_o
);
  logic [8:0] sum; // full 9-bit sum
  logic [4:0] low_sum; // low nibble sum for nibble carry

  // combinational result and flags
  always_comb begin
    sum = {1'b0, acc_i} + {1'b0, opnd_i};
    low_sum = {1'b0, acc_i[3:0]} + {1'b0, opnd_i[3:0]};
    res_o = add_i ? sum[7:0] : (acc_i & opnd_i);
    carry_o = sum[8]; // see RULE12
    nib_o = low_sum[BAO_NIB_BIT]; // see RULE12
    zero_o = (res_o == 8'h00); // see RULE12
  end
endmodule

//--- hdl/bao_core.sv
`timescale 1ns/1ps
// ****************************************
// byte alu and bit-operation datapath
// ****************************************
// one instruction per valid cycle; file data arrives combinationally from
// data memory (file_rdata_i for faddr_i) and writes retire next edge.
module bao_core
  import bao_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic op_valid_i, // instruction strobe
  input wire bao_op_t op_i, // operation
  input wire logic [7:0] lit_i, // literal k
  input wire logic [6:0] faddr_i, // file address f
  input wire logic dest_i, // 0 acc, 1 file
  input wire logic [2:0] bit_i, // bit index b
  input wire logic [7:0] file_rdata_i, // addressed file data
  input wire logic prog_mode_i, // programming/verify mode
  input wire logic id_we_i, // id write strobe
  input wire logic [13:0] id_addr_i, // program-space address
  input wire logic [13:0] id_wdata_i, // id write data
  output logic [6:0] file_addr_o,
  output logic file_we_o, // one-cycle write
  output logic [7:0] file_wdata_o,
  output logic [7:0] acc_o, // accumulator
  output logic carry_o,
  output logic nibble_overflow_flag_o,
  output logic zero_o,
  output logic flags_we_o, // pulse when flags were updated
  output logic skip_o, // next instruction discarded
  output logic [13:0] id_rdata_o // id read data
);
  // ****************************************
  // state
  // ****************************************
  logic [7:0] acc_q, acc_d; // accumulator
  logic c_q, c_d, dc_q, dc_d, z_q, z_d; // status bits
  logic fwe_q, fwe_d; // file write pulse
  logic [7:0] fwd_q, fwd_d; // file write data
  logic [6:0] fad_q, fad_d; // file write address
  logic flw_q, flw_d; // flag update pulse
  logic skip_q, skip_d; // discard-next marker
  logic [13:0] idr_q, idr_d; // id read port
  logic [BAO_ID_W-1:0] id_q [BAO_ID_NUM]; // id storage
  logic [BAO_ID_W-1:0] id_d [BAO_ID_NUM];

  logic [7:0] res; // alu result
  logic alu_c, alu_dc, alu_z; // alu flags
  logic is_add, is_lit; // operand steering
  logic [7:0] opnd; // second operand
  logic [7:0] bmask; // one-hot bit mask
  logic id_hit; // address within id window
  logic [1:0] id_idx; // id word index

  // operand selection
  always_comb begin
    is_add = (op_i == BAO_OP_ADD_LIT) || (op_i == BAO_OP_ADD_FILE);
    is_lit = (op_i == BAO_OP_ADD_LIT) || (op_i == BAO_OP_AND_LIT);
    opnd = is_lit ? lit_i : file_rdata_i;
    bmask = 8'h01 << bit_i;
  end

  bao_flag_calc u_calc (
    .acc_i(acc_q),
    .opnd_i(opnd),
    .add_i(is_add),
    .res_o(res),
    .carry_o(alu_c),
    .nib_o(alu_dc),
    .zero_o(alu_z)
  );

  // ****************************************
  // instruction execution
  // ****************************************
  // a skipped slot is executed as a nop: the cycle after a taken test
  // ignores whatever the decoder presents, giving the two-cycle form
  always_comb begin
    acc_d = acc_q;
    c_d = c_q;
    dc_d = dc_q;
    z_d = z_q;
    fwe_d = 1'b0;
    fwd_d = fwd_q;
    fad_d = fad_q;
    flw_d = 1'b0;
    skip_d = 1'b0;
    if (op_valid_i && !skip_q) begin
      unique case (op_i)
        BAO_OP_NONE: begin
          // nothing for this datapath
        end
        BAO_OP_ADD_LIT: begin
          acc_d = res; // see RULE4
          c_d = alu_c;
          dc_d = alu_dc;
          z_d = alu_z;
          flw_d = 1'b1;
        end
        BAO_OP_ADD_FILE, BAO_OP_AND_FILE: begin
          if (dest_i) begin // see RULE6
            fwe_d = 1'b1;
            fwd_d = res;
            fad_d = faddr_i;
          end else begin
            acc_d = res;
          end
          if (op_i == BAO_OP_ADD_FILE) begin // see RULE5
            c_d = alu_c;
            dc_d = alu_dc;
          end
          z_d = alu_z; // see RULE8
          flw_d = 1'b1;
        end
        BAO_OP_AND_LIT: begin
          acc_d = res; // see RULE7
          z_d = alu_z;
          flw_d = 1'b1;
        end
        BAO_OP_BIT_CLR: begin
          // whole byte rewritten, flags untouched
          fwe_d = 1'b1; // see RULE13
          fwd_d = file_rdata_i & ~bmask; // see RULE9
          fad_d = faddr_i;
        end
        BAO_OP_BIT_SET: begin
          fwe_d = 1'b1; // see RULE13
          fwd_d = file_rdata_i | bmask; // see RULE10
          fad_d = faddr_i;
        end
        BAO_OP_BIT_TST: begin
          skip_d = ~|(file_rdata_i & bmask); // see RULE11
        end
      endcase
    end
  end

  // ****************************************
  // identification words
  // ****************************************
  // only reachable in programming mode; core ops never touch them
  always_comb begin
    id_hit = (id_addr_i >= BAO_ID_BASE) && (id_addr_i <= BAO_ID_LAST); // see RULE1
    id_idx = id_addr_i[1:0];
    idr_d = 14'h0000;
    for (int i = 0; i < BAO_ID_NUM; i++) begin
      id_d[i] = id_q[i];
    end
    if (prog_mode_i && id_hit) begin // see RULE2
      idr_d = {7'h00, id_q[id_idx]}; // see RULE3
      if (id_we_i) begin
        id_d[id_idx] = id_wdata_i[BAO_ID_W-1:0]; // see RULE3
      end
    end
  end

  // registers
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      acc_q <= BAO_ACC_RST;
      c_q <= 1'b0;
      dc_q <= 1'b0;
      z_q <= 1'b0;
      fwe_q <= 1'b0;
      fwd_q <= 8'h00;
      fad_q <= 7'h00;
      flw_q <= 1'b0;
      skip_q <= 1'b0;
      idr_q <= 14'h0000;
      for (int i = 0; i < BAO_ID_NUM; i++) begin
        id_q[i] <= BAO_ID_RST;
      end
    end else begin
      acc_q <= acc_d;
      c_q <= c_d;
      dc_q <= dc_d;
      z_q <= z_d;
      fwe_q <= fwe_d;
      fwd_q <= fwd_d;
      fad_q <= fad_d;
      flw_q <= flw_d;
      skip_q <= skip_d;
      idr_q <= idr_d;
      for (int i = 0; i < BAO_ID_NUM; i++) begin
        id_q[i] <= id_d[i];
      end
    end
  end

  assign acc_o = acc_q;
  assign carry_o = c_q;
  assign nibble_overflow_flag_o = dc_q;
  assign zero_o = z_q;
  assign file_we_o = fwe_q;
  assign file_wdata_o = fwd_q;
  assign file_addr_o = fad_q;
  assign flags_we_o = flw_q;
  assign skip_o = skip_q;
  assign id_rdata_o = idr_q;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  add_lit_sum_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_ADD_LIT)
    |=> acc_o == $past(acc_q) + $past(lit_i)) else $error("add literal wrong"); // see RULE4
  add_carry_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_ADD_LIT)
    |=> carry_o == ({1'b0, $past(acc_q)} + {1'b0, $past(lit_i)} > 9'h0ff)) else $error("carry wrong"); // see RULE12
  add_dest_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_ADD_FILE && dest_i)
    |=> file_we_o && acc_o == $past(acc_q)) else $error("file dest wrong"); // see RULE6
  add_file_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_ADD_FILE && !dest_i)
    |=> acc_o == $past(acc_q) + $past(file_rdata_i) && !file_we_o) else $error("add file wrong"); // see RULE5
  and_flags_a: assert property ((op_valid_i && !skip_q && (op_i == BAO_OP_AND_LIT || op_i == BAO_OP_AND_FILE))
    |=> $stable(carry_o) && $stable(nibble_overflow_flag_o)) else $error("and changed carry"); // see RULE8
  and_lit_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_AND_LIT)
    |=> acc_o == ($past(acc_q) & $past(lit_i)) && zero_o == (acc_o == 8'h00)) else $error("and bad"); // see RULE7
  bit_clr_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_BIT_CLR)
    |=> file_we_o && !file_wdata_o[$past(bit_i)] && !flags_we_o) else $error("bit clear bad"); // see RULE9
  bit_set_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_BIT_SET)
    |=> file_we_o && file_wdata_o == ($past(file_rdata_i) | (8'h01 << $past(bit_i)))) else $error("bit set bad"); // see RULE10
  skip_nop_a: assert property (skip_o |-> ##1 (!file_we_o && !flags_we_o && !skip_o)) else $error("skip slot acted"); // see RULE11
  id_locked_a: assert property (!prog_mode_i |=> id_rdata_o == 14'h0000) else $error("id leaked"); // see RULE2
  id_width_a: assert property (id_rdata_o[13:7] == 7'h00) else $error("id upper bits set"); // see RULE3

  // ****************************************
  // flag and operand checks
  // ****************************************
  // zero must track the stored 8-bit sum, not the 9-bit one
  add_zero_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_ADD_LIT)
    |=> zero_o == (acc_o == 8'h00)) else $error("add zero wrong"); // see RULE12
  // nibble carry taken from an independent 5-bit sum
  nib_carry_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_ADD_LIT)
    |=> nibble_overflow_flag_o == (({1'b0, $past(acc_q[3:0])} + {1'b0, $past(lit_i[3:0])}) > 5'h0f))
    else $error("nibble carry wrong"); // see RULE12
  // a clear must keep every other bit of the byte
  clr_keep_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_BIT_CLR)
    |=> file_wdata_o == ($past(file_rdata_i) & ~(8'h01 << $past(bit_i)))) else $error("clear lost bits"); // see RULE9
  // bit ops leave accumulator and status alone
  bit_flags_a: assert property ((op_valid_i && !skip_q && (op_i == BAO_OP_BIT_CLR || op_i == BAO_OP_BIT_SET))
    |=> $stable(carry_o) && $stable(zero_o) && $stable(nibble_overflow_flag_o) && $stable(acc_o))
    else $error("bit op touched status"); // see RULE10
  // a set tested bit lets the next op run
  tst_pass_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_BIT_TST && |(file_rdata_i & bmask))
    |=> !skip_o) else $error("skip on set bit"); // see RULE11
  // a clear tested bit discards the next op
  tst_skip_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_BIT_TST && !(|(file_rdata_i & bmask)))
    |=> skip_o) else $error("no skip on clear bit"); // see RULE11
  // and into the accumulator from a file register
  and_file_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_AND_FILE && !dest_i)
    |=> acc_o == ($past(acc_q) & $past(file_rdata_i)) && !file_we_o) else $error("and file wrong"); // see RULE8
  // file destination writes back to the address given
  and_dest_a: assert property ((op_valid_i && !skip_q && op_i == BAO_OP_AND_FILE && dest_i)
    |=> file_we_o && file_addr_o == $past(faddr_i) && acc_o == $past(acc_q)) else $error("and dest wrong"); // see RULE6
  // a lookup in the window returns the stored word
  id_read_a: assert property ((prog_mode_i && id_hit)
    |=> id_rdata_o == {7'h00, $past(id_q[id_idx])}) else $error("id read wrong"); // see RULE1

  skip_taken_c: cover property (op_valid_i && op_i == BAO_OP_BIT_TST ##1 skip_o);
  add_carry_c: cover property (flags_we_o && carry_o && nibble_overflow_flag_o);
  file_write_c: cover property (file_we_o ##1 file_we_o);
  id_write_c: cover property (prog_mode_i && id_we_i && id_hit);
endmodule

//--- sim/bao_core_tb.sv
`timescale 1ns/1ps
module bao_core_tb;
  import bao_pkg::*;
  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic op_valid_i = 1'b0;
  bao_op_t op_i = BAO_OP_NONE;
  logic [7:0] lit_i = 8'h00;
  logic [6:0] faddr_i = 7'h00;
  logic dest_i = 1'b0;
  logic [2:0] bit_i = 3'h0;
  logic [7:0] file_rdata_i;
  logic prog_mode_i = 1'b0;
  logic id_we_i = 1'b0;
  logic [13:0] id_addr_i = 14'h0000;
  logic [13:0] id_wdata_i = 14'h0000;
  logic [6:0] file_addr_o;
  logic file_we_o, carry_o, nib_o, zero_o, flags_we_o, skip_o;
  logic [7:0] file_wdata_o, acc_o;
  logic [13:0] id_rdata_o;
  // ****************************************
  // reference state
  // ****************************************
  logic [7:0] mem [128]; // file registers, bench acts as data memory
  logic [6:0] idm [4]; // expected id words
  logic [7:0] acc = 8'h00;
  logic c = 1'b0, n = 1'b0, z = 1'b0;
  // expectations of the op in flight; start as the reset values
  logic p_we = 1'b0, p_fwe = 1'b0, p_sk = 1'b0;
  logic [7:0] p_wd = 8'h00;
  logic [6:0] p_fa = 7'h00;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  // combinational file read, as the data memory must give it
  assign file_rdata_i = mem[faddr_i];
  always #2 clk_i = ~clk_i;
  bao_core u_bao_core (.clk_i(clk_i), .rst_n_i(rst_n_i), .op_valid_i(op_valid_i), .op_i(op_i), .lit_i(lit_i),
    .faddr_i(faddr_i), .dest_i(dest_i), .bit_i(bit_i), .file_rdata_i(file_rdata_i), .prog_mode_i(prog_mode_i),
    .id_we_i(id_we_i), .id_addr_i(id_addr_i), .id_wdata_i(id_wdata_i), .file_addr_o(file_addr_o),
    .file_we_o(file_we_o), .file_wdata_o(file_wdata_o), .acc_o(acc_o), .carry_o(carry_o),
    .nibble_overflow_flag_o(nib_o), .zero_o(zero_o), .flags_we_o(flags_we_o), .skip_o(skip_o),
    .id_rdata_o(id_rdata_o));
  // ****************************************
  // helpers
  // ****************************************
  task automatic chk(input logic [13:0] g, input logic [13:0] e);
    checks++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic end_of_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // one op per call: check the previous op, then model and drive this one
  task automatic step(logic v, bao_op_t o, logic [7:0] k, logic [6:0] f, logic d, logic [2:0] b);
    logic [7:0] opn, r;
    logic [8:0] s;
    logic lit, run;
    @(negedge clk_i);
    if (p_we) mem[p_fa] = p_wd; // write lands only after its cycle
    chk(14'(acc_o), 14'(acc));
    chk(14'({carry_o, nib_o, zero_o}), 14'({c, n, z}));
    chk(14'({flags_we_o, file_we_o, skip_o}), 14'({p_fwe, p_we, p_sk}));
    if (p_we) chk(14'({file_addr_o, file_wdata_o}), 14'({p_fa, p_wd}));
    run = v && !p_sk; // the discarded slot executes as a no-op
    lit = (o == BAO_OP_ADD_LIT) || (o == BAO_OP_AND_LIT);
    opn = lit ? k : mem[f];
    {p_we, p_fwe, p_sk, r} = '0;
    p_fa = f;
    if (run) begin
      case (o)
        BAO_OP_ADD_LIT, BAO_OP_ADD_FILE: begin
          s = {1'b0, acc} + {1'b0, opn};
          c = s[8];
          n = ({1'b0, acc[3:0]} + {1'b0, opn[3:0]}) > 5'h0f;
          r = s[7:0];
          z = (r == 8'h00);
          p_fwe = 1'b1;
        end
        BAO_OP_AND_LIT, BAO_OP_AND_FILE: begin
          r = acc & opn;
          z = (r == 8'h00);
          p_fwe = 1'b1;
        end
        BAO_OP_BIT_CLR: {p_we, r} = {1'b1, opn & ~(8'h01 << b)};
        BAO_OP_BIT_SET: {p_we, r} = {1'b1, opn | (8'h01 << b)};
        BAO_OP_BIT_TST: p_sk = ~opn[b];
        default: ;
      endcase
    end
    // destination bit only matters for file forms
    if (p_fwe) begin
      if (!lit && d) p_we = 1'b1;
      else acc = r;
    end
    p_wd = r;
    {op_valid_i, op_i, lit_i, faddr_i, dest_i, bit_i} = {v, o, k, f, d, b};
  endtask
  // id access: one cycle lookup, read data checked the cycle after
  task automatic id_acc(logic pm, logic w, logic [13:0] a, logic [13:0] wd);
    logic hit;
    @(negedge clk_i);
    {prog_mode_i, id_we_i, id_addr_i, id_wdata_i} = {pm, w, a, wd};
    hit = pm && (a >= BAO_ID_BASE) && (a <= BAO_ID_LAST);
    @(negedge clk_i);
    id_we_i = 1'b0;
    if (w && hit) idm[a[1:0]] = wd[6:0];
    if (!w) chk(id_rdata_o, hit ? {7'h00, idm[a[1:0]]} : 14'h0000);
  endtask
  // ****************************************
  // timeout
  // ****************************************
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 5000) begin
      fails++;
      end_of_test();
    end
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    void'($urandom(85435));
    for (int i = 0; i < 128; i++) mem[i] = 8'($urandom);
    for (int i = 0; i < 4; i++) idm[i] = 7'h00;
    repeat (21) @(negedge clk_i);
    rst_n_i = 1'b1;
    // corner cases: zero, nibble carry, wrap, bit edges, one taken and one passed bit test
    step(1'b1, BAO_OP_AND_LIT, 8'h00, 7'h00, 1'b0, 3'h0);
    step(1'b1, BAO_OP_ADD_LIT, 8'h0f, 7'h00, 1'b0, 3'h0);
    step(1'b1, BAO_OP_ADD_LIT, 8'h01, 7'h00, 1'b0, 3'h0);
    step(1'b1, BAO_OP_ADD_LIT, 8'hf0, 7'h00, 1'b0, 3'h0);
    step(1'b1, BAO_OP_BIT_CLR, 8'h00, 7'h7f, 1'b0, 3'h7);
    step(1'b1, BAO_OP_BIT_TST, 8'h00, 7'h7f, 1'b0, 3'h7);
    step(1'b1, BAO_OP_BIT_SET, 8'h00, 7'h7f, 1'b0, 3'h0);
    step(1'b1, BAO_OP_BIT_SET, 8'h00, 7'h05, 1'b0, 3'h0);
    step(1'b1, BAO_OP_BIT_TST, 8'h00, 7'h05, 1'b0, 3'h0);
    step(1'b1, BAO_OP_ADD_FILE, 8'h00, 7'h05, 1'b1, 3'h0);
    step(1'b1, BAO_OP_AND_FILE, 8'h00, 7'h05, 1'b1, 3'h0);
    step(1'b0, BAO_OP_NONE, 8'h00, 7'h00, 1'b0, 3'h0);
    $display("test corner done");
    // random stream on few addresses to force back-to-back reuse
    repeat (600) begin
      step($urandom_range(0, 7) != 0, bao_op_t'($urandom_range(0, 7)), 8'($urandom),
        7'($urandom_range(0, 3)), 1'($urandom), 3'($urandom));
    end
    step(1'b0, BAO_OP_NONE, 8'h00, 7'h00, 1'b0, 3'h0);
    step(1'b0, BAO_OP_NONE, 8'h00, 7'h00, 1'b0, 3'h0);
    $display("test random done");
    // id words: prog-mode writes, ignored normal-mode writes, window edges
    for (int i = 0; i < 4; i++) begin
      id_acc(1'b1, 1'b1, BAO_ID_BASE + 14'(i), 14'($urandom));
      id_acc(1'b0, 1'b1, BAO_ID_BASE + 14'(i), 14'($urandom));
      id_acc(1'b1, 1'b0, BAO_ID_BASE + 14'(i), 14'h0000);
      id_acc(1'b0, 1'b0, BAO_ID_BASE + 14'(i), 14'h0000);
    end
    id_acc(1'b1, 1'b0, 14'h1fff, 14'h0000);
    id_acc(1'b1, 1'b0, 14'h2004, 14'h0000);
    $display("test id done");
    end_of_test();
  end
endmodule
